// *** core/pma_array.sv ***
// top of the macrocell array: fuse store, and-or array, ten cells
// assumes pins come from outside the clock domain; the bench resolves
// each two-way pin from ioOut and ioOe
//
// Behaviour
// RL1 - 22 inputs feed and-or array, 10 outputs
// RL2 - each output ors 8 to 16 terms
// RL3 - own enable term; false floats the pin
// RL4 - set term loads ones at next edge
// RL5 - reset term clears registers at once
// RL6 - set and reset shared by all registers
// RL7 - pin shows register through chosen polarity
// RL8 - two select bits pick mode and polarity
// RL9 - fuse bit 0 intact, 1 blown
// RL10 - disabled output pin serves as array input; the code feeds the pin back only in combinational mode, else the register
// RL11 - power-up clears registers; active-low pins high
// RL12 - tester preloads registers, value held
// RL13 - security bit blocks readback, reads open
// RL14 - combinational follows sum; register captures it
// RL15 - reset beats set at same edge
`timescale 1ns/1ps
module pma_array
	import pma_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [pma_pkg::NUM_DED-1:0] dedInput, // input pins
	input wire logic [pma_pkg::NUM_MC-1:0] ioIn, // two-way pin level
	output logic [pma_pkg::NUM_MC-1:0] ioOut,
	output logic [pma_pkg::NUM_MC-1:0] ioOe,
	input wire logic fuseWrEn, // blow fuses of one row
	input wire logic [pma_pkg::ADDR_W-1:0] fuseAddr,
	input wire logic [pma_pkg::NUM_COL-1:0] fuseWrData,
	input wire logic selWrEn, // blow select fuses
	input wire logic [pma_pkg::NUM_MC-1:0] polarityData,
	input wire logic [pma_pkg::NUM_MC-1:0] feedbackData,
	input wire logic securityBlow, // blow the security fuse
	input wire logic preloadEn, // tester preload strobe
	input wire logic [pma_pkg::NUM_MC-1:0] preloadData,
	output logic [pma_pkg::NUM_COL-1:0] fuseRdData, // readback word
	output logic secured, // security fuse state
	output logic [pma_pkg::NUM_MC-1:0] regState // register contents
);
	import pma_pkg::*;

	logic [NUM_COL-1:0] fuseMem [NUM_ROW]; // array fuses per row
	logic [NUM_MC-1:0] polaritySelect; // per-cell polarity fuse
	logic [NUM_MC-1:0] feedbackModeSelect; // per-cell mode fuse
	logic [NUM_DED-1:0] dedMeta; // first sync stage, inputs
	logic [NUM_DED-1:0] dedSync; // second sync stage, inputs
	logic [NUM_MC-1:0] ioMeta; // first sync stage, pins
	logic [NUM_MC-1:0] ioSync; // second sync stage, pins
	logic [NUM_MC-1:0] feedback; // per-cell feedback into array
	logic [NUM_IN-1:0] arrayIn; // all array signal sources
	logic [NUM_COL-1:0] literal; // true and complement columns
	logic [NUM_ROW-1:0] term; // product terms
	logic [NUM_MC-1:0] sumTerm; // per-cell or of its terms
	logic [NUM_MC-1:0] oeTerm; // per-cell enable terms
	logic setTerm; // shared synchronous set
	logic resetTerm; // shared asynchronous reset

	// two flip-flops on every pin before the array sees it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dedMeta <= '0;
			dedSync <= '0;
			ioMeta <= '0;
			ioSync <= '0;
		end else begin
			dedMeta <= dedInput;
			dedSync <= dedMeta;
			ioMeta <= ioIn;
			ioSync <= ioMeta;
		end
	end

	// array fuses: writes only blow, a blown fuse stays blown until sys_rst
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int r = 0; r < NUM_ROW; r++) begin
				fuseMem[r] <= {NUM_COL{FUSE_INTACT}}; // RL9
			end
		end else if (fuseWrEn && fuseAddr <= ROW_LAST) begin
			fuseMem[fuseAddr] <= fuseMem[fuseAddr] | fuseWrData; // RL9
		end
	end

	// select fuses, two per macrocell
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			polaritySelect <= {NUM_MC{FUSE_INTACT}};
			feedbackModeSelect <= {NUM_MC{FUSE_INTACT}};
		end else if (selWrEn) begin
			polaritySelect <= polaritySelect | polarityData; // RL8 RL9
			feedbackModeSelect <= feedbackModeSelect | feedbackData;
		end
	end

	// security fuse, sticky once blown until sys_rst
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			secured <= FUSE_INTACT;
		end else if (securityBlow) begin
			secured <= FUSE_BLOWN;
		end
	end

	// readback; a secured part shows every fuse open
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fuseRdData <= '0;
		end else if (secured) begin
			fuseRdData <= {NUM_COL{FUSE_BLOWN}}; // RL13
		end else if (fuseAddr == ROW_SEL) begin
			// select fuses in the low bits, rest reads zero
			fuseRdData <= {{(NUM_COL-SEL_W){1'b0}},
				feedbackModeSelect, polaritySelect};
		end else if (fuseAddr <= ROW_LAST) begin
			fuseRdData <= fuseMem[fuseAddr];
		end else begin
			// rows past the map read zero
			fuseRdData <= '0;
		end
	end

	// array sources: dedicated inputs then macrocell feedback
	assign arrayIn = {feedback, dedSync}; // RL1 RL10

	// each source gives a true and a complement column
	genvar i;
	generate
		for (i = 0; i < NUM_IN; i++) begin : gLit
			assign literal[2*i] = arrayIn[i];
			assign literal[2*i+1] = ~arrayIn[i];
		end
	endgenerate

	// an intact fuse ties its column into the and; blown drops it
	genvar r;
	generate
		for (r = 0; r < NUM_ROW; r++) begin : gTerm
			assign term[r] = &(fuseMem[r] | literal); // RL1 RL9
		end
	endgenerate

	// shared set and reset terms for all registers
	assign resetTerm = term[ROW_RESET]; // RL6
	assign setTerm = term[ROW_SET]; // RL6

	// per cell: enable term, its own count of sum terms, the cell
	genvar k;
	generate
		for (k = 0; k < NUM_MC; k++) begin : gCell
			localparam int OE = oeRow(k);
			localparam int CNT = TERM_COUNT[k];
			assign oeTerm[k] = term[OE]; // RL3
			assign sumTerm[k] = |term[OE+1 +: CNT]; // RL2
			pma_macrocell uCell (
				.clock(clock),
				.sys_rst(sys_rst),
				.sumTerm(sumTerm[k]),
				.oeTerm(oeTerm[k]),
				.setTerm(setTerm),
				.resetTerm(resetTerm),
				.polaritySelect(polaritySelect[k]),
				.feedbackModeSelect(feedbackModeSelect[k]),
				.preloadEn(preloadEn),
				.preloadBit(preloadData[k]),
				.pinIn(ioSync[k]),
				.pinOut(ioOut[k]),
				.pinOe(ioOe[k]),
				.feedback(feedback[k]),
				.regState(regState[k])
			);

			// fully blown enable row: term true, pin driven
			oe_follow_a: assert property (@(posedge clock) // RL3
				disable iff (sys_rst) &fuseMem[OE] |-> ioOe[k])
				else $error("blown enable row left pin floating");
			// intact enable row holds x and not x: pin floats
			oe_blank_a: assert property (@(posedge clock) // RL3
				disable iff (sys_rst) fuseMem[OE] == '0 |-> !ioOe[k])
				else $error("intact enable row drove the pin");
		end
	endgenerate

	// checks on the array as a whole
	secure_read_a: assert property (@(posedge clock) // RL13
		disable iff (sys_rst) secured |=> &fuseRdData)
		else $error("secured readback not all open");
	secure_stick_a: assert property (@(posedge clock) // RL13
		disable iff (sys_rst) secured |=> secured)
		else $error("security fuse restored");
	powerup_clear_a: assert property (@(posedge clock) // RL11
		$fell(sys_rst) |-> regState == '0)
		else $error("registers not clear after power-up");
	shared_reset_a: assert property (@(posedge clock) // RL6
		disable iff (sys_rst) resetTerm && $past(resetTerm)
		|-> regState == '0)
		else $error("reset term missed a register");
	pin_feedback_a: assert property (@(posedge clock) // RL10
		disable iff (sys_rst)
		arrayIn[NUM_IN-1:NUM_DED] == ((feedbackModeSelect & ioSync)
		| (~feedbackModeSelect & regState)))
		else $error("feedback source wrong");

	// a set edge with no reset in it or in the cycle after
	sequence setWindow;
		setTerm && !resetTerm && !preloadEn ##1 !resetTerm;
	endsequence

	// one set term reaches every register at once
	shared_set_a: assert property (@(posedge clock) // RL4 RL6
		disable iff (sys_rst) setWindow |-> regState == '1)
		else $error("set term missed a register");
	// select row readback shows the fuses as they stood
	sel_read_a: assert property (@(posedge clock) // RL8 RL9
		disable iff (sys_rst) !secured && fuseAddr == ROW_SEL
		|=> fuseRdData[SEL_W-1:0]
		== $past({feedbackModeSelect, polaritySelect}))
		else $error("select fuse readback wrong");
	// a blown select fuse returns to intact only at sys_rst
	fuse_stick_a: assert property (@(posedge clock) // RL9
		disable iff (sys_rst) ##1 ((($past(polaritySelect)
		& ~polaritySelect) | ($past(feedbackModeSelect)
		& ~feedbackModeSelect)) == '0))
		else $error("blown select fuse restored");
endmodule // pma_array

// *** core/pma_pkg.sv ***
// package for the macrocell array: sizes, array row map, term counts
// assumes a single 100 MHz clock domain and no register bus
package pma_pkg;
	localparam int NUM_DED = 12; // dedicated array inputs
	localparam int NUM_MC = 10; // output macrocells
	localparam int NUM_IN = NUM_DED + NUM_MC; // array signal sources
	localparam int NUM_COL = 2 * NUM_IN; // true and complement columns
	localparam int NUM_ROW = 132; // product-term rows
	localparam int ADDR_W = 8; // fuse row address width
	localparam int SEL_W = 2 * NUM_MC; // select fuse readback width
	// shared reset term, then per macrocell its enable and sum terms
	localparam logic [ADDR_W-1:0] ROW_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ROW_SET = 8'h83;
	localparam logic [ADDR_W-1:0] ROW_SEL = 8'h84; // select fuse row
	localparam logic [ADDR_W-1:0] ROW_LAST = 8'h83; // last term row
	// sum terms per macrocell, macrocell 0 first
	localparam int TERM_COUNT [NUM_MC] = '{8, 10, 12, 14, 16,
		16, 14, 12, 10, 8};
	localparam logic FUSE_INTACT = 1'b0; // unprogrammed fuse
	localparam logic FUSE_BLOWN = 1'b1; // programmed, reads open

	// row of the enable term of macrocell k; its sum terms follow it
	function automatic int oeRow(input int k);
		int r;
		r = 1;
		for (int j = 0; j < k; j++) begin
			r = r + TERM_COUNT[j] + 1;
		end
		return r;
	endfunction
endpackage

// *** core/pma_macrocell.sv ***
// one output macrocell: register, polarity, feedback select, enable
// assumes product terms arrive from the array in the clock domain
`timescale 1ns/1ps
module pma_macrocell (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic sumTerm, // or of this cell's product terms
	input wire logic oeTerm, // this cell's output enable term
	input wire logic setTerm, // shared synchronous set term
	input wire logic resetTerm, // shared asynchronous reset term
	input wire logic polaritySelect, // 1 active high
	input wire logic feedbackModeSelect, // 1 combinational, pin fb
	input wire logic preloadEn, // tester preload strobe
	input wire logic preloadBit, // value to preload
	input wire logic pinIn, // synchronised pin level
	output logic pinOut,
	output logic pinOe,
	output logic feedback,
	output logic regState
);
	logic outBit; // value before polarity

	// output register; async reset term and power-up clear give 0
	always_ff @(posedge clock or posedge sys_rst
		or posedge resetTerm) begin
		if (sys_rst || resetTerm) begin
			regState <= 1'b0; // RL5 RL11 RL15
		end else if (preloadEn) begin
			regState <= preloadBit; // RL12
		end else if (setTerm) begin
			regState <= 1'b1; // RL4
		end else begin
			regState <= sumTerm; // RL14
		end
	end

	// pick registered or combinational source
	always_comb begin
		outBit = feedbackModeSelect ? sumTerm : regState; // RL8 RL14
	end

	// polarity and enable drive the pin
	assign pinOut = polaritySelect ? outBit : ~outBit; // RL7
	assign pinOe = oeTerm; // RL3
	// register feedback or pin feedback
	assign feedback = feedbackModeSelect ? pinIn : regState; // RL10

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence setCause;
		setTerm && !resetTerm && !preloadEn ##1 !resetTerm;
	endsequence
	sequence loadCause;
		!setTerm && !resetTerm && !preloadEn ##1 !resetTerm;
	endsequence
	sequence preloadCause;
		preloadEn && !resetTerm ##1 !resetTerm;
	endsequence

	set_load_a: assert property (setCause |-> regState) // RL4
		else $error("set term did not load one");
	reg_capture_a: assert property ( // RL14
		loadCause |-> regState == $past(sumTerm))
		else $error("register missed sum term");
	preload_hold_a: assert property ( // RL12
		preloadCause |-> regState == $past(preloadBit))
		else $error("preload value not held");
	reset_wins_a: assert property ( // RL15
		resetTerm && setTerm ##1 resetTerm |-> !regState)
		else $error("set overrode async reset");
	async_clear_a: assert property ( // RL5
		resetTerm && $past(resetTerm) |-> regState == 1'b0)
		else $error("register not cleared by reset term");
	reg_out_a: assert property ( // RL7
		!feedbackModeSelect |-> pinOut == (regState ~^ polaritySelect))
		else $error("registered pin polarity wrong");
	comb_out_a: assert property ( // RL14
		feedbackModeSelect |-> pinOut == (sumTerm ~^ polaritySelect))
		else $error("combinational pin wrong");
endmodule // pma_macrocell

// *** verif/pma_board.sv ***
// board model around the two-way pins of the macrocell array
// assumes ioOut and ioOe come straight from the array
`timescale 1ns/1ps
module pma_board (
	input wire logic clock,
	input wire logic [9:0] ioOut,
	input wire logic [9:0] ioOe,
	input wire logic [9:0] extVal, // board drive level
	input wire logic [9:0] extEn, // board drives the pin
	output logic [9:0] ioIn
);
	logic [9:0] floatVal = 10'h155; // undriven pins wander
	// undriven level changes every cycle, never a stale value
	always_ff @(posedge clock) begin
		floatVal <= ~floatVal;
	end
	// array driver first, then the board, else floating
	always_comb begin
		ioIn = (ioOe & ioOut) | (~ioOe & extEn & extVal)
			| (~ioOe & ~extEn & floatVal);
	end
endmodule // pma_board

// *** verif/tb.sv ***
// self-checking bench for the macrocell array
// assumes the board model resolves each two-way pin
`timescale 1ns/1ps
module tb;
	import pma_pkg::*;
	logic clock = 1'b0;
	logic sysRst = 1'b1; // held at start
	logic [11:0] dedInput = 12'h000;
	logic [9:0] ioIn, ioOut, ioOe, regState, rnd;
	logic [9:0] extVal = 10'h000; // board drive level
	logic [9:0] extEn = 10'h000; // board drives pin
	logic [9:0] polarityData = 10'h000, feedbackData = 10'h000;
	logic [9:0] preloadData = 10'h000;
	logic fuseWrEn = 1'b0, selWrEn = 1'b0, preloadEn = 1'b0;
	logic securityBlow = 1'b0, secured;
	logic [7:0] fuseAddr = 8'h00;
	logic [43:0] fuseWrData = 44'h0, fuseRdData;
	int n_fail = 0;
	int n_compared = 0;
	int row; // enable row of the current cell
	int modelReg; // register contents the rules predict
	int want; // expected value from the model
	int oeWant[$]; // expected enable words, oldest first
	// rule model of the pins: mode picks register or sum, then polarity
	function automatic int pinModel(input int regv, input int sumv,
		input int pol, input int fb);
		int x;
		x = (fb & sumv) | (~fb & regv);
		return ((pol & x) | (~pol & ~x)) & 32'h3ff;
	endfunction
	pma_array i_dut (.clock(clock), .sys_rst(sysRst), .dedInput(dedInput),
		.ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .fuseWrEn(fuseWrEn),
		.fuseAddr(fuseAddr), .fuseWrData(fuseWrData), .selWrEn(selWrEn),
		.polarityData(polarityData), .feedbackData(feedbackData),
		.securityBlow(securityBlow), .preloadEn(preloadEn),
		.preloadData(preloadData), .fuseRdData(fuseRdData),
		.secured(secured), .regState(regState));
	pma_board i_board (.clock(clock), .ioOut(ioOut), .ioOe(ioOe),
		.extVal(extVal), .extEn(extEn), .ioIn(ioIn));
	// 100 MHz clock
	initial forever #5 clock = ~clock;
	// compare and count
	task automatic check(input logic [43:0] seen, input logic [43:0] want,
		input string what);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// wait edges, then let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic doReset();
		@(posedge clock);
		sysRst <= 1'b1;
		repeat (10) @(posedge clock);
		sysRst <= 1'b0;
		tick(1);
	endtask
	// blow one row; taken at the edge where the task returns
	task automatic blow(input int r, input logic [43:0] d);
		@(posedge clock);
		fuseWrEn <= 1'b1;
		fuseAddr <= 8'(r);
		fuseWrData <= d;
		@(posedge clock);
		fuseWrEn <= 1'b0;
		#1;
	endtask
	task automatic selWrite(input logic [9:0] pol, input logic [9:0] fb);
		@(posedge clock);
		selWrEn <= 1'b1;
		polarityData <= pol;
		feedbackData <= fb;
		fuseAddr <= 8'h84;
		@(posedge clock);
		selWrEn <= 1'b0;
	endtask
	initial begin
		rnd = 10'($urandom(32'he45c));
		doReset();
		modelReg = 0; // power-up clear
		want = pinModel(modelReg, 0, 0, 0);
		check(regState, modelReg, "regs after reset");
		check(ioOut, want, "pins after reset");
		check(ioOe, 0, "enables after reset");
		$display("test reset done");
		rnd = 10'($urandom);
		@(posedge clock);
		preloadEn <= 1'b1;
		preloadData <= rnd;
		tick(2);
		modelReg = rnd; // preload wins over the sum
		want = pinModel(modelReg, 0, 0, 0);
		check(regState, modelReg, "preload held");
		check(ioOut, want, "active low pins");
		@(posedge clock);
		preloadEn <= 1'b0;
		tick(1);
		modelReg = 0; // blank array: every sum term false
		check(regState, modelReg, "sum captured");
		$display("test preload done");
		blow(ROW_SET, '1);
		tick(1);
		modelReg = 32'h3ff; // shared set loads every register
		want = pinModel(modelReg, 0, 0, 0);
		check(regState, modelReg, "shared set");
		check(ioOut, want, "set seen low");
		blow(ROW_RESET, '1);
		modelReg = 0; // reset term acts without a clock
		check(regState, modelReg, "reset at once");
		tick(2);
		check(regState, modelReg, "reset beats set");
		$display("test set and reset done");
		doReset();
		rnd = 10'($urandom);
		selWrite(rnd, 10'h3ff);
		tick(2);
		check(fuseRdData, {24'h0, 10'h3ff, rnd}, "select readback");
		want = pinModel(0, 0, rnd, 32'h3ff); // sums all false
		check(ioOut, want, "comb polarity");
		row = 1;
		for (int k = 0; k < NUM_MC; k++) begin
			oeWant.push_back((1 << (k + 1)) - 1); // enables so far
		end
		for (int k = 0; k < NUM_MC; k++) begin
			blow(row, '1);
			check(ioOe, oeWant.pop_front(), "own enable");
			row = row + TERM_COUNT[k] + 1;
		end
		@(posedge clock);
		securityBlow <= 1'b1;
		@(posedge clock);
		securityBlow <= 1'b0;
		tick(2);
		check(secured, 1, "secured");
		check(fuseRdData, '1, "locked readback");
		$display("test select and lock done");
		doReset();
		rnd = 10'($urandom) | 10'h001; // cell 0 registered, active high
		selWrite(rnd, 10'h002);
		blow(9, ~(44'h1 << 26)); // last term of cell 0 follows pin 1
		blow(8, ~(44'h1 << 22)); // the term before it follows input 11
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			extEn <= 10'h002;
			extVal[1] <= i[0];
			dedInput[11] <= i[1];
			tick(4);
			modelReg = (i != 0); // or of input 11 and pin 1
			want = pinModel(modelReg, 0, rnd, 32'h002) & 1;
			check(regState[0], modelReg, "pin feedback or");
			check(ioOut[0], want, "active high register");
		end
		$display("test pin feedback done");
		complete_run();
	end
	// cut a hang short; the tests need well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clock);
		n_fail++;
		$display("MISMATCH %0t watchdog expired", $time);
		complete_run();
	end
endmodule // tb
